//--- rtl/fan_cfg_pkg.sv
package fan_cfg_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
    localparam int TIMEOUT_MS = 25;
    localparam logic [12:0] WINDOW_BASE_MS = 13'h0fa;
    localparam logic [2:0] WINDOW_MAX_CODE = 3'h5;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_BLOCK_LEN = 8'h00;
    localparam logic [7:0] OFF_CFG1 = 8'h01;
    localparam logic [7:0] OFF_CFG2 = 8'h02;
    localparam logic [7:0] OFF_CFG3 = 8'h03;
    localparam logic [7:0] OFF_CFG4 = 8'h04;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BLOCK_LEN = 8'h20;
    localparam logic [7:0] RST_CFG1 = 8'h01;
    localparam logic [7:0] RST_CFG2 = 8'h84;
    localparam logic [7:0] RST_CFG3 = 8'h04;
    localparam logic [7:0] RST_CFG4 = 8'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG1_TABLE = 7;
    localparam int CFG1_LOCK = 6;
    localparam int CFG1_SDA_TO = 5;
    localparam int CFG1_SCL_TO = 4;
    localparam int CFG1_ALERT = 3;
    localparam int CFG1_TIMER = 2;
    localparam int CFG1_AVG_OFF = 1;
    localparam int CFG1_MONITOR = 0;
    localparam int CFG2_RR = 7;
    localparam int CFG2_CHSEL_LO = 4;
    localparam int CFG2_LINEAR = 2;
    localparam int CFG2_BOOST_DIS = 1;
    localparam int CFG2_SWRST = 0;
    localparam int CFG3_POLES_LO = 0;
    localparam int CFG4_REF = 7;
    localparam int CFG4_WIN_LO = 4;
    localparam int CFG4_XOR = 3;
    localparam int CFG4_REM_EV = 1;
    localparam int CFG4_LOC_EV = 0;
    // ------------------------------------------------------------
    // bus constants
    // ------------------------------------------------------------
    localparam logic [7:0] BLOCK_MAX = 8'h20;
    localparam logic [3:0] FAST_RATE_CODE = 4'h8;
    localparam logic [7:0] UNMAPPED_DATA = 8'hff;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2e;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_RX_ACK,
        ST_WDATA,
        ST_RDATA,
        ST_RDATA_ACK
    } bus_state_t;
endpackage

//--- rtl/bus_line_monitor.sv
`timescale 1ns/10ps
module bus_line_monitor
    import fan_cfg_pkg::*;
#(
    parameter int CYC_PER_MS = CYCLES_PER_MS,
    parameter int TO_MS = TIMEOUT_MS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // raw bus pins
    input wire logic scl_pin,
    input wire logic sda_pin,
    // timeout enables
    input wire logic sda_to_en,
    input wire logic scl_to_en,
    // line events
    output logic scl_rise,
    output logic scl_fall,
    output logic start_seen,
    output logic stop_seen,
    output logic sda_level,
    output logic ms_tick,
    output logic bus_timeout
);
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_d;
        logic sda_d;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda_level;
        logic [31:0] ms_div;
        logic ms_tick;
        logic [7:0] scl_low_ms;
        logic [7:0] sda_low_ms;
        logic timeout;
    } mon_t;

    mon_t m;
    mon_t next_m;

    always_comb begin
        next_m = m;
        // first sync stage feeds only the second
        next_m.scl_sync = {m.scl_sync[0], scl_pin};
        next_m.sda_sync = {m.sda_sync[0], sda_pin};
        next_m.scl_d = m.scl_sync[1];
        next_m.sda_d = m.sda_sync[1];
        next_m.sda_level = m.sda_sync[1];
        next_m.scl_rise = m.scl_sync[1] & ~m.scl_d;
        next_m.scl_fall = ~m.scl_sync[1] & m.scl_d;
        next_m.start = m.scl_sync[1] & m.scl_d & m.sda_d & ~m.sda_sync[1];
        next_m.stop = m.scl_sync[1] & m.scl_d & ~m.sda_d & m.sda_sync[1];
        // millisecond enable for all slow timing
        next_m.ms_tick = 1'b0;
        if (m.ms_div >= 32'(CYC_PER_MS - 1)) begin
            next_m.ms_div = '0;
            next_m.ms_tick = 1'b1;
        end else begin
            next_m.ms_div = m.ms_div + 32'h1;
        end
        if (m.scl_d) begin
            next_m.scl_low_ms = '0;
        end else if (m.ms_tick && m.scl_low_ms != 8'hff) begin
            next_m.scl_low_ms = m.scl_low_ms + 8'h1;
        end
        if (m.sda_d) begin
            next_m.sda_low_ms = '0;
        end else if (m.ms_tick && m.sda_low_ms != 8'hff) begin
            next_m.sda_low_ms = m.sda_low_ms + 8'h1;
        end
        next_m.timeout = 1'b0;
        if ((scl_to_en && m.scl_low_ms >= 8'(TO_MS)) ||
            (sda_to_en && m.sda_low_ms >= 8'(TO_MS))) begin
            next_m.timeout = 1'b1;
            next_m.scl_low_ms = '0;
            next_m.sda_low_ms = '0;
        end
    end

    // lines idle high, so the synchronisers start high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m <= '0;
            m.scl_sync <= 2'h3;
            m.sda_sync <= 2'h3;
            m.scl_d <= 1'b1;
            m.sda_d <= 1'b1;
            m.sda_level <= 1'b1;
        end else begin
            m <= next_m;
        end
    end

    assign scl_rise = m.scl_rise;
    assign scl_fall = m.scl_fall;
    assign start_seen = m.start;
    assign stop_seen = m.stop;
    assign sda_level = m.sda_level;
    assign ms_tick = m.ms_tick;
    assign bus_timeout = m.timeout;
endmodule

//--- rtl/thermal_fan_config_registers.sv
`timescale 1ns/10ps
// Operation
// - block read returns as many bytes as block length holds, at most 32
// - config one bit 7 picks look-up table fan control, else manual
// - lock bit set: all host writes to lockable registers ignored
// - config one bit 5 enables data-line timeout, default off
// - config one bit 4 enables clock-line timeout, default off
// - config one bit 3 picks comparator alert instead of standard alert
// - config one bit 2 enables overtemp timer; pin becomes input
// - bit 1 turns averaging off at slow rates; fast rates never average
// - config one bit 0 enables monitoring, else standby; resets to one
// - config two bit 7 gives round-robin, else single channel
// - channel select 00 local, 01 remote; other codes reserved
// - config two bit 2 picks linear fan profile, else discrete speeds
// - config two bit 1 stops fan boost on overtemp events
// - writing config two bit 0 restores defaults, bit clears itself
// - config three low nibble holds fan pole count, default four
// - config four bit 7 picks shared pin role: fault out or reference
// - window field doubles 0.25 s to 8 s; codes above five stay 8 s
// - config four bit 3 enables the pin connectivity test
// - remote over limit with timer and bit 1 asserts overtemp pin
// - local over limit with timer and bit 0 asserts overtemp pin
// - all five registers lockable and restored by software reset
module thermal_fan_config_registers
    import fan_cfg_pkg::*;
#(
    parameter int CYC_PER_MS = CYCLES_PER_MS,
    parameter int TO_MS = TIMEOUT_MS,
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // overtemp pin
    input wire logic overtemp_pin_in,
    output logic overtemp_pin_out,
    output logic overtemp_pin_oe_n,
    // measurement side
    input wire logic local_over_limit,
    input wire logic remote_over_limit,
    input wire logic [3:0] conv_rate_code,
    // configuration to the rest of the chip
    output logic fan_table_control_select,
    output logic registers_locked,
    output logic alert_comparator_mode,
    output logic monitoring_enable,
    output logic averaging_enable,
    output logic round_robin_enable,
    output logic [1:0] channel_select,
    output logic linear_fan_profile,
    output logic boost_disable,
    output logic [3:0] fan_pole_count,
    output logic ref_input_select,
    output logic xor_test_enable,
    // overtemp status
    output logic overtemp_input_active,
    output logic overtemp_duty_window_end
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] block_len;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] cfg3;
        logic [7:0] cfg4;
        bus_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic [7:0] rd_count;
        logic rw;
        logic acked;
        logic sda_out;
        logic sda_oe_n;
        logic ot_out;
        logic ot_oe_n;
        logic [1:0] ot_sync;
        logic ot_in_active;
        logic [12:0] win_ms;
        logic win_end;
        logic avg_en;
    } regs_t;

    regs_t s;
    regs_t next_s;
    logic wr_fire;
    logic software_register_reset;
    logic load_rd;
    logic [7:0] rd_byte;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_level;
    logic ms_tick;
    logic bus_timeout;

    function automatic logic [12:0] window_ms(input logic [2:0] code);
        logic [2:0] sh;
        sh = (code > WINDOW_MAX_CODE) ? WINDOW_MAX_CODE : code;
        return WINDOW_BASE_MS << sh;
    endfunction

    function automatic logic [7:0] eff_len(input logic [7:0] len);
        return (len > BLOCK_MAX) ? BLOCK_MAX : len;
    endfunction

    function automatic logic [7:0] read_reg(input regs_t r, input logic [7:0] addr);
        case (addr)
            OFF_BLOCK_LEN: read_reg = r.block_len;
            OFF_CFG1: read_reg = r.cfg1;
            OFF_CFG2: read_reg = r.cfg2;
            OFF_CFG3: read_reg = r.cfg3;
            OFF_CFG4: read_reg = r.cfg4;
            default: read_reg = UNMAPPED_DATA;
        endcase
    endfunction

    // ------------------------------------------------------------
    // bus line sampling
    // ------------------------------------------------------------
    bus_line_monitor #(
        .CYC_PER_MS(CYC_PER_MS),
        .TO_MS(TO_MS)
    ) u_mon (
        .clk(clk),
        .rst_n(rst_n),
        .scl_pin(scl_in),
        .sda_pin(sda_in),
        .sda_to_en(s.cfg1[CFG1_SDA_TO]),
        .scl_to_en(s.cfg1[CFG1_SCL_TO]),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_seen(start_seen),
        .stop_seen(stop_seen),
        .sda_level(sda_level),
        .ms_tick(ms_tick),
        .bus_timeout(bus_timeout)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        wr_fire = 1'b0;
        software_register_reset = 1'b0;
        load_rd = 1'b0;
        rd_byte = (s.rd_count >= eff_len(s.block_len)) ? UNMAPPED_DATA
                                                       : read_reg(s, s.ptr);
        // pin is active low and only ever pulled, never driven high
        next_s.ot_sync = {s.ot_sync[0], overtemp_pin_in};
        next_s.ot_oe_n = ~(s.cfg1[CFG1_TIMER] &
            ((s.cfg4[CFG4_REM_EV] & remote_over_limit) |
             (s.cfg4[CFG4_LOC_EV] & local_over_limit)));
        next_s.ot_in_active = s.cfg1[CFG1_TIMER] & ~s.ot_sync[1];
        next_s.avg_en = ~s.cfg1[CFG1_AVG_OFF] & (conv_rate_code < FAST_RATE_CODE);
        next_s.win_end = 1'b0;
        if (!s.cfg1[CFG1_TIMER]) begin
            next_s.win_ms = '0;
        end else if (ms_tick) begin
            if (s.win_ms >= window_ms(s.cfg4[CFG4_WIN_LO +: 3]) - 13'h1) begin
                next_s.win_ms = '0;
                next_s.win_end = 1'b1;
            end else begin
                next_s.win_ms = s.win_ms + 13'h1;
            end
        end
        // a stuck line aborts the frame just like a stop
        if (bus_timeout || stop_seen) begin
            next_s.st = ST_IDLE;
            next_s.sda_oe_n = 1'b1;
        end else if (start_seen) begin
            next_s.st = ST_ADDR;
            next_s.bit_cnt = '0;
            next_s.rd_count = '0;
            next_s.sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            case (s.st)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    next_s.shreg = {s.shreg[6:0], sda_level};
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                end
                ST_RDATA: begin
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                end
                ST_RDATA_ACK: begin
                    next_s.acked = ~sda_level;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (s.st)
                ST_ADDR: begin
                    if (s.bit_cnt == BYTE_BITS) begin
                        if (s.shreg[7:1] == DEV_ADDR) begin
                            next_s.st = ST_ADDR_ACK;
                            next_s.rw = s.shreg[0];
                            next_s.sda_oe_n = 1'b0;
                        end else begin
                            next_s.st = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    next_s.bit_cnt = '0;
                    if (s.rw) begin
                        load_rd = 1'b1;
                    end else begin
                        next_s.st = ST_PTR;
                        next_s.sda_oe_n = 1'b1;
                    end
                end
                ST_PTR: begin
                    if (s.bit_cnt == BYTE_BITS) begin
                        next_s.ptr = s.shreg;
                        next_s.st = ST_RX_ACK;
                        next_s.sda_oe_n = 1'b0;
                    end
                end
                ST_RX_ACK: begin
                    next_s.st = ST_WDATA;
                    next_s.bit_cnt = '0;
                    next_s.sda_oe_n = 1'b1;
                end
                ST_WDATA: begin
                    if (s.bit_cnt == BYTE_BITS) begin
                        wr_fire = 1'b1;
                        next_s.ptr = s.ptr + 8'h1;
                        next_s.st = ST_RX_ACK;
                        next_s.sda_oe_n = 1'b0;
                    end
                end
                ST_RDATA: begin
                    if (s.bit_cnt == BYTE_BITS) begin
                        next_s.st = ST_RDATA_ACK;
                        next_s.sda_oe_n = 1'b1;
                    end else begin
                        next_s.shreg = {s.shreg[6:0], 1'b0};
                        next_s.sda_oe_n = s.shreg[6];
                    end
                end
                ST_RDATA_ACK: begin
                    next_s.bit_cnt = '0;
                    if (s.acked) begin
                        load_rd = 1'b1;
                    end else begin
                        next_s.st = ST_IDLE;
                    end
                end
                default: begin
                    next_s.st = ST_IDLE;
                end
            endcase
        end
        // a 1 bit is sent by releasing the line
        if (load_rd) begin
            next_s.st = ST_RDATA;
            next_s.shreg = rd_byte;
            next_s.sda_oe_n = rd_byte[7];
            next_s.ptr = s.ptr + 8'h1;
            if (s.rd_count != 8'hff) begin
                next_s.rd_count = s.rd_count + 8'h1;
            end
        end
        // lock has no unlock path short of a power-on reset
        if (wr_fire && !s.cfg1[CFG1_LOCK]) begin
            case (s.ptr)
                OFF_BLOCK_LEN: next_s.block_len = s.shreg;
                OFF_CFG1: next_s.cfg1 = s.shreg;
                OFF_CFG2: begin
                    if (s.shreg[CFG2_SWRST]) begin
                        software_register_reset = 1'b1;
                    end else begin
                        next_s.cfg2 = s.shreg;
                    end
                end
                OFF_CFG3: next_s.cfg3 = s.shreg;
                OFF_CFG4: next_s.cfg4 = s.shreg;
                default: begin
                end
            endcase
        end
        if (software_register_reset) begin
            next_s.block_len = RST_BLOCK_LEN;
            next_s.cfg1 = RST_CFG1;
            next_s.cfg2 = RST_CFG2;
            next_s.cfg3 = RST_CFG3;
            next_s.cfg4 = RST_CFG4;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.block_len <= RST_BLOCK_LEN;
            s.cfg1 <= RST_CFG1;
            s.cfg2 <= RST_CFG2;
            s.cfg3 <= RST_CFG3;
            s.cfg4 <= RST_CFG4;
            s.st <= ST_IDLE;
            s.sda_oe_n <= 1'b1;
            s.ot_oe_n <= 1'b1;
            s.ot_sync <= 2'h3;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sda_out = s.sda_out;
    assign sda_oe_n = s.sda_oe_n;
    assign overtemp_pin_out = s.ot_out;
    assign overtemp_pin_oe_n = s.ot_oe_n;
    assign fan_table_control_select = s.cfg1[CFG1_TABLE];
    assign registers_locked = s.cfg1[CFG1_LOCK];
    assign alert_comparator_mode = s.cfg1[CFG1_ALERT];
    assign monitoring_enable = s.cfg1[CFG1_MONITOR];
    assign averaging_enable = s.avg_en;
    assign round_robin_enable = s.cfg2[CFG2_RR];
    assign channel_select = s.cfg2[CFG2_CHSEL_LO +: 2];
    assign linear_fan_profile = s.cfg2[CFG2_LINEAR];
    assign boost_disable = s.cfg2[CFG2_BOOST_DIS];
    assign fan_pole_count = s.cfg3[CFG3_POLES_LO +: 4];
    assign ref_input_select = s.cfg4[CFG4_REF];
    assign xor_test_enable = s.cfg4[CFG4_XOR];
    assign overtemp_input_active = s.ot_in_active;
    assign overtemp_duty_window_end = s.win_end;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence software_register_reset_write;
        wr_fire && s.ptr == OFF_CFG2 && s.shreg[CFG2_SWRST] && !s.cfg1[CFG1_LOCK];
    endsequence

    sequence at_defaults;
        s.block_len == RST_BLOCK_LEN && s.cfg1 == RST_CFG1 && s.cfg2 == RST_CFG2 &&
            s.cfg3 == RST_CFG3 && s.cfg4 == RST_CFG4;
    endsequence

    AST_LOCK_FREEZE: assert property (s.cfg1[CFG1_LOCK] |=>
        $stable({s.block_len, s.cfg1, s.cfg2, s.cfg3, s.cfg4}))
        else $error("locked registers changed");
    AST_SWRST_DEFAULTS: assert property (software_register_reset_write |=> at_defaults)
        else $error("software reset did not restore defaults");
    AST_SWRST_SELF_CLEAR: assert property (software_register_reset_write |=> !s.cfg2[CFG2_SWRST] [*3])
        else $error("software reset bit did not clear");
    AST_OT_REMOTE: assert property (
        s.cfg1[CFG1_TIMER] && s.cfg4[CFG4_REM_EV] && remote_over_limit |=> !overtemp_pin_oe_n)
        else $error("overtemp pin not asserted for remote event");
    AST_OT_LOCAL: assert property (
        s.cfg1[CFG1_TIMER] && s.cfg4[CFG4_LOC_EV] && local_over_limit |=> !overtemp_pin_oe_n)
        else $error("overtemp pin not asserted for local event");
    AST_OT_TIMER_OFF: assert property (!s.cfg1[CFG1_TIMER] |=> overtemp_pin_oe_n)
        else $error("overtemp pin driven with timer off");
    AST_AVG_FAST: assert property (conv_rate_code >= FAST_RATE_CODE |=> !averaging_enable)
        else $error("averaging on at fast rate");
    AST_AVG_SLOW: assert property (
        conv_rate_code < FAST_RATE_CODE && !s.cfg1[CFG1_AVG_OFF] |=> averaging_enable)
        else $error("averaging off at slow rate");
    AST_WINDOW_LEN: assert property (s.win_end |->
        $past(s.win_ms) == window_ms(s.cfg4[CFG4_WIN_LO +: 3]) - 13'h1)
        else $error("duty window ended at wrong count");
    AST_BLOCK_LIMIT: assert property (
        s.st == ST_RDATA && s.rd_count > eff_len(s.block_len) |-> s.sda_oe_n)
        else $error("data driven past block length");
    AST_TIMEOUT_IDLE: assert property (bus_timeout |=> s.st == ST_IDLE && s.sda_oe_n)
        else $error("bus timeout did not release the bus");
endmodule

//--- bench/bus_host_model.sv
`timescale 1ns/10ps
module bus_host_model (
    // bus lines
    output logic scl,
    output logic sda_drv,
    input wire logic sda_wire
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // ----------------------------------------
    // line steps, a quarter of a 125 ns clock
    // ----------------------------------------
    // data moves only while scl is low, so no false start or stop
    task automatic st(input logic c, input logic d);
        scl = c;
        sda_drv = d;
        #31.25;
    endtask
    task automatic start();
        st(scl, 1'b1);
        st(1'b1, 1'b1);
        st(1'b1, 1'b0);
        st(1'b0, 1'b0);
    endtask
    task automatic stop();
        st(1'b0, 1'b0);
        st(1'b1, 1'b0);
        st(1'b1, 1'b1);
    endtask
    task automatic xbyte(input logic [7:0] d, input logic nk, output logic [7:0] r,
                         output logic ak);
        for (int i = 8; i >= 0; i--) begin
            // half-period low so the device's own sda change settles before scl rises
            st(1'b0, (i == 0) ? nk : d[i-1]);
            st(1'b0, (i == 0) ? nk : d[i-1]);
            st(1'b1, (i == 0) ? nk : d[i-1]);
            if (i == 0) ak = sda_wire;
            else r[i-1] = sda_wire;
            st(1'b1, (i == 0) ? nk : d[i-1]);
        end
        st(1'b0, nk);
    endtask
    // ----------------------------------------
    // register cycles
    // ----------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
                      output logic [2:0] ak);
        logic [7:0] r;
        start();
        xbyte({a, 1'b0}, 1'b1, r, ak[2]);
        xbyte(o, 1'b1, r, ak[1]);
        xbyte(d, 1'b1, r, ak[0]);
        stop();
    endtask
    // n data bytes, host acks all but the last; d keeps the last byte
    task automatic rd(input logic [6:0] a, input logic [7:0] o, input int n,
                      output logic [7:0] d);
        logic ak;
        start();
        xbyte({a, 1'b0}, 1'b1, d, ak);
        xbyte(o, 1'b1, d, ak);
        start();
        xbyte({a, 1'b1}, 1'b1, d, ak);
        for (int k = n; k > 0; k--) begin
            xbyte(8'hff, k == 1, d, ak);
        end
        stop();
    endtask
endmodule

//--- bench/thermal_fan_config_registers_tb.sv
`timescale 1ns/10ps
module thermal_fan_config_registers_tb;
    import fan_cfg_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, loc = 1'b0, rem = 1'b0, sda_out, oe_n, ot_out, ot_oe_n;
    logic scl, sda_drv, ot_act, we, tbl, lck, alc, mon, avg, rr, lin, bst, rfs, xr;
    logic [3:0] rate = 4'h0, poles;
    logic [1:0] chs;
    logic [2:0] ak;
    logic [7:0] rd;
    logic [7:0] dflt [5] = '{8'h20, 8'h01, 8'h84, 8'h04, 8'h00};
    int err_total = 0, n_checks = 0, cyc;
    wire logic sda_w = sda_drv & (oe_n | sda_out);
    always #5 clk = ~clk;
    bus_host_model host (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_w));
    thermal_fan_config_registers #(.CYC_PER_MS(10), .TO_MS(2)) dut (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_n(oe_n), .overtemp_pin_in(ot_oe_n | ot_out), .overtemp_pin_out(ot_out),
        .overtemp_pin_oe_n(ot_oe_n), .local_over_limit(loc), .remote_over_limit(rem),
        .conv_rate_code(rate), .fan_table_control_select(tbl), .registers_locked(lck),
        .alert_comparator_mode(alc), .monitoring_enable(mon), .averaging_enable(avg),
        .round_robin_enable(rr), .channel_select(chs), .linear_fan_profile(lin),
        .boost_disable(bst), .fan_pole_count(poles), .ref_input_select(rfs),
        .xor_test_enable(xr), .overtemp_input_active(ot_act),
        .overtemp_duty_window_end(we));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        host.wr(DEV_ADDR_DEFAULT, o, d, ak);
        chk({13'h0, ak}, 16'h0);
        repeat (4) @(negedge clk);
    endtask
    task automatic rdc(input logic [7:0] o, input logic [7:0] e);
        host.rd(DEV_ADDR_DEFAULT, o, 1, rd);
        chk({8'h0, rd}, {8'h0, e});
    endtask
    task automatic finish_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // pulse is one cycle wide, so sample every falling edge
    task automatic wait_we();
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
        end while (we !== 1'b1 && cyc < 9000);
        if (cyc >= 9000) begin
            chk(16'h0, 16'h1);
            finish_test();
        end
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        foreach (dflt[i]) rdc(8'(i), dflt[i]);
        chk({8'h0, mon, rr, lin, 1'b0, poles}, 16'h00e4);
        rdc(8'h05, 8'hff);
        wr(8'h01, 8'h8a);
        chk({8'h0, tbl, alc, mon, avg, 4'h0}, 16'h00c0);
        wr(8'h01, 8'h80);
        rate = 4'h7;
        repeat (2) @(negedge clk);
        chk({15'h0, avg}, 16'h1);
        rate = 4'h8;
        repeat (2) @(negedge clk);
        chk({15'h0, avg}, 16'h0);
        wr(8'h02, 8'h1a);
        chk({8'h0, rr, chs, lin, bst, 3'h0}, 16'h0028);
        rdc(8'h02, 8'h1a);
        wr(8'h03, 8'h06);
        wr(8'h04, 8'hb8);
        chk({8'h0, rfs, xr, 2'h0, poles}, 16'h00c6);
        rdc(8'h04, 8'hb8);
        wr(8'h04, 8'h01);
        wr(8'h01, 8'h04);
        loc = 1'b1;
        repeat (6) @(negedge clk);
        chk({14'h0, ot_oe_n, ot_act}, 16'h1);
        loc = 1'b0;
        rem = 1'b1;
        repeat (6) @(negedge clk);
        chk({14'h0, ot_oe_n, ot_act}, 16'h2);
        wr(8'h04, 8'h02);
        chk({14'h0, ot_oe_n, ot_act}, 16'h1);
        wait_we();
        wait_we();
        chk(16'(cyc), 16'h09c4);
        // block length of one: the second byte of the read must come back released
        wr(8'h00, 8'h01);
        host.rd(DEV_ADDR_DEFAULT, 8'h00, 2, rd);
        chk({8'h0, rd}, 16'h00ff);
        // clock line held low past the limit aborts the frame, so no address ack
        wr(8'h01, 8'h10);
        host.start();
        #500;
        host.xbyte({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rd, ak[0]);
        host.stop();
        chk({15'h0, ak[0]}, 16'h1);
        wr(8'h02, 8'h01);
        foreach (dflt[i]) rdc(8'(i), dflt[i]);
        wr(8'h01, 8'h40);
        wr(8'h03, 8'h0a);
        rdc(8'h03, 8'h04);
        chk({15'h0, lck}, 16'h1);
        finish_test();
    end
endmodule
